// File: ltgm_top.sv
// Contract
// [R1] Generator and monitor share one packet count
// [R2] Packet count even, 2 to 65534
// [R3] Generator sends only after lock and alignment
// [R4] Monitor receives only after lock and alignment
// [R5] Lock, alignment and segmented bus handshake exchanged
// [R6] Fixed length toggles SOP/EOP on all segments
// [R7] Packet mode channel counts 0..255, wraps
// [R8] Burst mode alternates two fixed channels
// [R9] Generator drives flow control and error injection
// [R10] Monitor observes flow control and injection status
// [R11] Flow-control blocks exist only when enabled
// [R12] 12.5 Gb/s uses one shared 300MHz clock
// [R13] 25.78125 Gb/s uses 300MHz bus, 412MHz core
// [R14] Swap reverses bit order core to transceiver
// [R15] Restart only when both sides idle
// [R16] Done raised after all packets sent
// [R17] Fail raised on buffer overflow or underflow
// [R18] Monitor checks contents, sequence, count; flags errors
// [R19] Busy held from start until done or fail
`timescale 1ns/1ps
`include "ltgm_regs.svh"
module ltgm_top #(
  parameter int PKT_NUM                = 100,
  parameter int LINE_RATE_KBPS         = `LTGM_RATE_LO_KBPS,
  parameter bit INBAND_FLOW_CTRL_EN    = 1'b1,
  parameter bit OUTOFBAND_FLOW_CTRL_EN = 1'b1
) (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [7:0]                 addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic [31:0]                     rdata_o,
  output logic                            irq_o,
  input  wire logic                       restart_i,
  input  wire logic                       serial_transceiver_locked_i,
  input  wire logic                       rx_aligned_i,
  output ltgm_pkg::ltgm_lbus_t            tx_o,
  input  wire logic                       tx_rdy_i,
  input  wire logic                       tx_ovf_i,
  input  wire logic                       tx_unf_i,
  input  ltgm_pkg::ltgm_lbus_t            rx_i,
  output logic                            err_inj_o,
  input  wire logic                       core_err_i,
  output logic [`LTGM_NFC-1:0][`LTGM_FCW-1:0] fc_tx_o,
  input  wire logic [`LTGM_NFC-1:0][`LTGM_FCW-1:0] fc_rx_i,
  input  wire logic [`LTGM_SWW-1:0]       core_txd_i,
  output logic [`LTGM_SWW-1:0]            ser_txd_o,
  input  wire logic [`LTGM_SWW-1:0]       ser_rxd_i,
  output logic [`LTGM_SWW-1:0]            core_rxd_o,
  output logic                            tx_done_o,
  output logic                            tx_fail_o,
  output logic                            tx_busy_o,
  output logic                            rx_busy_o,
  output logic                            rx_done_o,
  output logic                            rx_err_o,
  output logic                            locked_o,
  output logic                            two_clk_cfg_o
);
  import ltgm_pkg::*;

  if ((PKT_NUM % 2) != 0 || PKT_NUM < 2 || PKT_NUM > 65534) begin : g_bad_num
    $error("packet count must be even, 2 to 65534"); // [R2]
  end
  if (LINE_RATE_KBPS != `LTGM_RATE_LO_KBPS &&
      LINE_RATE_KBPS != `LTGM_RATE_HI_KBPS) begin : g_bad_rate
    $error("unsupported line rate");
  end

  localparam bit TWO_CLK = (LINE_RATE_KBPS == `LTGM_RATE_HI_KBPS);
  localparam bit [`LTGM_NFC-1:0] FC_EN =
    {OUTOFBAND_FLOW_CTRL_EN, INBAND_FLOW_CTRL_EN};

  function automatic logic [`LTGM_SWW-1:0] ltgm_rev(
    input logic [`LTGM_SWW-1:0] d);
    logic [`LTGM_SWW-1:0] r;
    r = '0;
    for (int i = 0; i < `LTGM_SWW; i++) begin
      r[i] = d[`LTGM_SWW-1-i];
    end
    return r;
  endfunction

  typedef struct packed {
    logic                   started;
    logic                   start;
    ltgm_mode_e             mode;
    logic                   inj;
    logic [`LTGM_NEV-1:0]   ist;
    logic [`LTGM_NEV-1:0]   imask;
    logic [`LTGM_NEV-1:0]   prev;
    logic [31:0]            rdata;
    logic                   irq;
    logic                   locked;
    logic                   aligned;
    logic                   two_clk;
    logic [`LTGM_SWW-1:0]   txd;
    logic [`LTGM_SWW-1:0]   rxd;
  } ltgm_top_s;

  ltgm_top_s                             t_reg;
  ltgm_top_s                             t_next;
  logic                                  link_up;
  logic                                  gen_busy;
  logic                                  gen_done;
  logic                                  gen_fail;
  logic                                  mon_busy;
  logic                                  mon_done;
  logic                                  mon_err;
  logic [`LTGM_CNTW-1:0]                 sent;
  logic [`LTGM_CNTW-1:0]                 rcvd;
  logic [`LTGM_NEV-1:0]                  ev;
  logic [`LTGM_NEV-1:0]                  rise;
  logic [`LTGM_NEV-1:0]                  w1c;
  logic                                  req;
  logic                                  wr_ctrl;
  logic [`LTGM_NFC-1:0][`LTGM_FCW-1:0]   fc_seen;

  // Both status levels are taken as already synchronous to clk_i
  assign link_up = serial_transceiver_locked_i && rx_aligned_i; // [R5]

  ltgm_pkt_gen #(
    .PKT_NUM (PKT_NUM)
  ) u_gen (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (t_reg.start),
    .mode_i    (t_reg.mode),
    .link_up_i (link_up),
    .tx_rdy_i  (tx_rdy_i),
    .tx_ovf_i  (tx_ovf_i),
    .tx_unf_i  (tx_unf_i),
    .tx_o      (tx_o),
    .busy_o    (gen_busy),
    .done_o    (gen_done),
    .fail_o    (gen_fail),
    .sent_o    (sent)
  ); // [R1]

  ltgm_pkt_mon #(
    .PKT_NUM (PKT_NUM)
  ) u_mon (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (t_reg.start),
    .mode_i    (t_reg.mode),
    .link_up_i (link_up),
    .rx_i      (rx_i),
    .busy_o    (mon_busy),
    .done_o    (mon_done),
    .err_o     (mon_err),
    .rcvd_o    (rcvd)
  ); // [R1]

  // Flow-control calendars walk a single bit while a run is in progress
  for (genvar k = 0; k < `LTGM_NFC; k++) begin : g_fc
    if (FC_EN[k]) begin : g_on // [R11]
      logic [`LTGM_FCW-1:0] cal_reg;
      logic [`LTGM_FCW-1:0] seen_reg;
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cal_reg <= `LTGM_FC_SEED;
          seen_reg <= '0;
        end else begin
          if (gen_busy) begin
            cal_reg <= {cal_reg[`LTGM_FCW-2:0], cal_reg[`LTGM_FCW-1]}; // [R9]
          end
          if (t_reg.start) begin
            seen_reg <= '0;
          end else begin
            seen_reg <= seen_reg | fc_rx_i[k]; // [R10]
          end
        end
      end
      assign fc_tx_o[k] = cal_reg;
      assign fc_seen[k] = seen_reg;
    end else begin : g_off
      assign fc_tx_o[k] = '0;
      assign fc_seen[k] = '0;
    end
  end

  always_comb begin
    t_next = t_reg;
    wr_ctrl = wr_i && (addr_i == `LTGM_A_CTRL);
    req = restart_i || (wr_ctrl && wdata_i[`LTGM_CTRL_RST]);
    ev = {core_err_i, mon_err, mon_done, gen_fail, gen_done};
    rise = ev & ~t_reg.prev;
    w1c = '0;
    t_next.prev = ev;
    t_next.started = 1'b1;
    // First run starts by itself after reset
    t_next.start = !t_reg.started ||
                   (req && !gen_busy && !mon_busy); // [R15]
    t_next.inj = wr_ctrl && wdata_i[`LTGM_CTRL_INJ]; // [R9]
    if (wr_ctrl) begin
      t_next.mode = ltgm_mode_e'(wdata_i[`LTGM_CTRL_MODE]);
    end
    if (wr_i && addr_i == `LTGM_A_MASK) begin
      t_next.imask = wdata_i[`LTGM_NEV-1:0];
    end
    if (wr_i && addr_i == `LTGM_A_INT) begin
      w1c = wdata_i[`LTGM_NEV-1:0];
    end
    // A new event beats a clear landing in the same cycle
    t_next.ist = (t_reg.ist & ~w1c) | rise; // [R10]
    t_next.irq = |(t_next.ist & t_next.imask);
    t_next.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        `LTGM_A_CTRL: t_next.rdata = 32'({t_reg.mode, 1'b0});
        `LTGM_A_STAT: t_next.rdata = 32'({t_reg.two_clk, t_reg.aligned,
                                          t_reg.locked, mon_err, mon_done,
                                          mon_busy, gen_fail, gen_done,
                                          gen_busy});
        `LTGM_A_INT:  t_next.rdata = 32'(t_reg.ist);
        `LTGM_A_MASK: t_next.rdata = 32'(t_reg.imask);
        `LTGM_A_CNT:  t_next.rdata = {rcvd, sent};
        `LTGM_A_FC:   t_next.rdata = {fc_seen[1], fc_seen[0]}; // [R10]
        default:      t_next.rdata = '0;
      endcase
    end
    t_next.locked = serial_transceiver_locked_i;
    t_next.aligned = rx_aligned_i;
    // One shared clock below the high rate, else a separate core clock
    t_next.two_clk = TWO_CLK; // [R12] [R13]
    t_next.txd = ltgm_rev(core_txd_i); // [R14]
    t_next.rxd = ltgm_rev(ser_rxd_i); // [R14]
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      t_reg <= '0;
      t_reg.imask <= `LTGM_MASK_RST;
    end else begin
      t_reg <= t_next;
    end
  end

  assign rdata_o = t_reg.rdata;
  assign irq_o = t_reg.irq;
  assign err_inj_o = t_reg.inj;
  assign ser_txd_o = t_reg.txd;
  assign core_rxd_o = t_reg.rxd;
  assign tx_done_o = gen_done;
  assign tx_fail_o = gen_fail;
  assign tx_busy_o = gen_busy;
  assign rx_busy_o = mon_busy;
  assign rx_done_o = mon_done;
  assign rx_err_o = mon_err;
  assign locked_o = t_reg.locked;
  assign two_clk_cfg_o = t_reg.two_clk;

  property p_swap;
    @(posedge clk_i) disable iff (sys_rst_i)
    ##1 ser_txd_o == ltgm_rev($past(core_txd_i)) &&
        ltgm_rev(core_rxd_o) == $past(ser_rxd_i);
  endproperty
  a_swap: assert property (p_swap) // [R14]
    else $error("bit swap stage wrong");
  property p_restart;
    @(posedge clk_i) disable iff (sys_rst_i)
    (t_reg.started && restart_i && (tx_busy_o || rx_busy_o))
      |=> !t_reg.start;
  endproperty
  a_restart: assert property (p_restart) // [R15]
    else $error("restart taken while busy");
  property p_rate;
    @(posedge clk_i) disable iff (sys_rst_i)
    t_reg.started |-> two_clk_cfg_o == TWO_CLK;
  endproperty
  a_rate: assert property (p_rate) // [R13]
    else $error("clock configuration wrong");
  property p_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
    rise[0] |=> t_reg.ist[0] ##1 (t_reg.ist[0] || $past(w1c[0]));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("done event lost");
endmodule

// File: ltgm_regs.svh
`ifndef LTGM_REGS_SVH
`define LTGM_REGS_SVH
`define LTGM_NSEG 4
`define LTGM_SEGW 64
`define LTGM_CHW 8
`define LTGM_CNTW 16
`define LTGM_SWW 64
`define LTGM_FCW 16
`define LTGM_NFC 2
`define LTGM_LAST_POS 3'h4
`define LTGM_DPKT_LSB 48
`define LTGM_CH_A 8'h0A
`define LTGM_CH_B 8'h15
`define LTGM_FC_SEED 16'h0001
`define LTGM_A_CTRL 8'h00
`define LTGM_A_STAT 8'h04
`define LTGM_A_INT 8'h08
`define LTGM_A_MASK 8'h0C
`define LTGM_A_CNT 8'h10
`define LTGM_A_FC 8'h14
`define LTGM_CTRL_RST 0
`define LTGM_CTRL_MODE 1
`define LTGM_CTRL_INJ 2
`define LTGM_NEV 5
`define LTGM_MASK_RST 5'h00
`define LTGM_RATE_LO_KBPS 12500000
`define LTGM_RATE_HI_KBPS 25781250
`define LTGM_LBUS_MHZ 300
`define LTGM_CORE_HI_MHZ 412
`endif

// File: ltgm_pkg.sv
`include "ltgm_regs.svh"
package ltgm_pkg;
  typedef enum logic [2:0] {
    LTGM_IDLE = 3'b000,
    LTGM_WAIT = 3'b001,
    LTGM_RUN  = 3'b010,
    LTGM_DONE = 3'b011,
    LTGM_FAIL = 3'b100
  } ltgm_state_e;
  typedef enum logic {
    LTGM_PKT   = 1'b0,
    LTGM_BURST = 1'b1
  } ltgm_mode_e;
  typedef struct packed {
    logic                  ena;
    logic                  sop;
    logic                  eop;
    logic                  err;
    logic [`LTGM_CHW-1:0]  chan;
    logic [`LTGM_SEGW-1:0] data;
  } ltgm_seg_s;
  typedef ltgm_seg_s [`LTGM_NSEG-1:0] ltgm_lbus_t;
  // Five segments a packet on four lanes walks SOP/EOP over all of them
  function automatic ltgm_seg_s ltgm_mk_seg(
    input logic [`LTGM_CNTW-1:0] pkt,
    input logic [2:0]            pos,
    input ltgm_mode_e            mode);
    ltgm_seg_s s;
    s.ena  = 1'b1;
    s.sop  = (pos == 3'h0); // [R6]
    s.eop  = (pos == `LTGM_LAST_POS); // [R6]
    s.err  = 1'b0;
    s.chan = (mode == LTGM_PKT) ? pkt[7:0] : // [R7]
             (pkt[0] ? `LTGM_CH_B : `LTGM_CH_A); // [R8]
    s.data = {pkt, 13'h0, pos, ~pkt, 13'h0, pos};
    return s;
  endfunction
endpackage

// File: ltgm_pkt_gen.sv
`timescale 1ns/1ps
`include "ltgm_regs.svh"
module ltgm_pkt_gen #(
  parameter int PKT_NUM = 100
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  start_i,
  input  ltgm_pkg::ltgm_mode_e       mode_i,
  input  wire logic                  link_up_i,
  input  wire logic                  tx_rdy_i,
  input  wire logic                  tx_ovf_i,
  input  wire logic                  tx_unf_i,
  output ltgm_pkg::ltgm_lbus_t       tx_o,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       fail_o,
  output logic [`LTGM_CNTW-1:0]      sent_o
);
  import ltgm_pkg::*;
  localparam logic [`LTGM_CNTW-1:0] TOT = `LTGM_CNTW'(PKT_NUM);
  typedef struct packed {
    ltgm_state_e           st;
    logic [2:0]            pos;
    logic [`LTGM_CNTW-1:0] pkt;
    ltgm_mode_e            mode;
    ltgm_lbus_t            bus;
    logic                  busy;
    logic                  done;
    logic                  fail;
  } ltgm_gen_s;
  ltgm_gen_s             g_reg;
  ltgm_gen_s             g_next;
  logic [`LTGM_CNTW-1:0] p;
  logic [2:0]            q;
  always_comb begin
    g_next = g_reg;
    g_next.bus = '0;
    p = g_reg.pkt;
    q = g_reg.pos;
    unique case (g_reg.st)
      LTGM_IDLE, LTGM_DONE, LTGM_FAIL: begin
        if (start_i) begin
          g_next = '0;
          g_next.st = LTGM_WAIT;
          g_next.mode = mode_i;
          g_next.busy = 1'b1; // [R19]
        end
      end
      LTGM_WAIT: begin
        if (link_up_i) begin
          g_next.st = LTGM_RUN; // [R3]
        end
      end
      LTGM_RUN: begin
        if (tx_ovf_i || tx_unf_i) begin
          g_next.st = LTGM_FAIL; // [R17]
          g_next.fail = 1'b1;
          g_next.busy = 1'b0;
        end else if (link_up_i && tx_rdy_i) begin // [R3]
          for (int i = 0; i < `LTGM_NSEG; i++) begin
            if (p < TOT) begin // [R1]
              g_next.bus[i] = ltgm_mk_seg(p, q, g_reg.mode);
              if (q == `LTGM_LAST_POS) begin
                q = 3'h0;
                p = p + `LTGM_CNTW'(1);
              end else begin
                q = q + 3'h1;
              end
            end
          end
          g_next.pkt = p;
          g_next.pos = q;
          if (p == TOT) begin
            g_next.st = LTGM_DONE; // [R16]
            g_next.done = 1'b1;
            g_next.busy = 1'b0;
          end
        end
      end
      default: g_next.st = LTGM_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      g_reg <= '0;
    end else begin
      g_reg <= g_next;
    end
  end
  assign tx_o = g_reg.bus;
  assign busy_o = g_reg.busy;
  assign done_o = g_reg.done;
  assign fail_o = g_reg.fail;
  assign sent_o = g_reg.pkt;

  property p_done_cnt;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(done_o) |-> sent_o == TOT && tx_o[0].ena;
  endproperty
  a_done_cnt: assert property (p_done_cnt) // [R16]
    else $error("done without full packet count");
  property p_fail;
    @(posedge clk_i) disable iff (sys_rst_i)
    (g_reg.st == LTGM_RUN && (tx_ovf_i || tx_unf_i))
      |=> fail_o && !busy_o && !tx_o[0].ena;
  endproperty
  a_fail: assert property (p_fail) // [R17]
    else $error("fifo error did not raise fail");
  property p_link;
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_o[0].ena |-> $past(link_up_i) && $past(tx_rdy_i);
  endproperty
  a_link: assert property (p_link) // [R3]
    else $error("traffic sent without link up");
  property p_chan_pkt;
    @(posedge clk_i) disable iff (sys_rst_i)
    (tx_o[1].ena && g_reg.mode == LTGM_PKT)
      |-> tx_o[1].chan == tx_o[1].data[`LTGM_DPKT_LSB +: 8];
  endproperty
  a_chan_pkt: assert property (p_chan_pkt) // [R7]
    else $error("packet mode channel wrong");
  property p_chan_burst;
    @(posedge clk_i) disable iff (sys_rst_i)
    (tx_o[2].ena && g_reg.mode == LTGM_BURST)
      |-> tx_o[2].chan == (tx_o[2].data[`LTGM_DPKT_LSB] ?
                           `LTGM_CH_B : `LTGM_CH_A);
  endproperty
  a_chan_burst: assert property (p_chan_burst) // [R8]
    else $error("burst mode channel wrong");
  property p_busy;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(busy_o) |-> !done_o && !fail_o ##1 busy_o;
  endproperty
  a_busy: assert property (p_busy) // [R19]
    else $error("busy not held from start");
endmodule

// File: ltgm_pkt_mon.sv
`timescale 1ns/1ps
`include "ltgm_regs.svh"
module ltgm_pkt_mon #(
  parameter int PKT_NUM = 100
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  start_i,
  input  ltgm_pkg::ltgm_mode_e       mode_i,
  input  wire logic                  link_up_i,
  input  ltgm_pkg::ltgm_lbus_t       rx_i,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       err_o,
  output logic [`LTGM_CNTW-1:0]      rcvd_o
);
  import ltgm_pkg::*;
  localparam logic [`LTGM_CNTW-1:0] TOT = `LTGM_CNTW'(PKT_NUM);
  typedef struct packed {
    ltgm_state_e           st;
    logic [2:0]            pos;
    logic [`LTGM_CNTW-1:0] pkt;
    ltgm_mode_e            mode;
    logic                  busy;
    logic                  done;
    logic                  err;
  } ltgm_mon_s;
  ltgm_mon_s             m_reg;
  ltgm_mon_s             m_next;
  logic [`LTGM_CNTW-1:0] p;
  logic [2:0]            q;
  logic                  bad;
  always_comb begin
    m_next = m_reg;
    p = m_reg.pkt;
    q = m_reg.pos;
    bad = 1'b0;
    unique case (m_reg.st)
      LTGM_IDLE, LTGM_DONE, LTGM_FAIL: begin
        if (start_i) begin
          m_next = '0;
          m_next.st = LTGM_WAIT;
          m_next.mode = mode_i;
          m_next.busy = 1'b1; // [R19]
        end
      end
      LTGM_WAIT: begin
        if (link_up_i) begin
          m_next.st = LTGM_RUN; // [R4]
        end
      end
      LTGM_RUN: begin
        for (int i = 0; i < `LTGM_NSEG; i++) begin
          if (rx_i[i].ena) begin
            if (p >= TOT || rx_i[i] != ltgm_mk_seg(p, q, m_reg.mode)) begin
              bad = 1'b1; // [R18]
            end
            if (q == `LTGM_LAST_POS) begin
              q = 3'h0;
              p = p + `LTGM_CNTW'(1);
            end else begin
              q = q + 3'h1;
            end
          end
        end
        m_next.pkt = p;
        m_next.pos = q;
        if (bad) begin
          m_next.st = LTGM_FAIL; // [R18]
          m_next.err = 1'b1;
          m_next.busy = 1'b0;
        end else if (p == TOT) begin
          m_next.st = LTGM_DONE; // [R1]
          m_next.done = 1'b1;
          m_next.busy = 1'b0;
        end
      end
      default: m_next.st = LTGM_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_reg <= '0;
    end else begin
      m_reg <= m_next;
    end
  end
  assign busy_o = m_reg.busy;
  assign done_o = m_reg.done;
  assign err_o = m_reg.err;
  assign rcvd_o = m_reg.pkt;

  property p_mismatch;
    @(posedge clk_i) disable iff (sys_rst_i)
    (m_reg.st == LTGM_RUN && rx_i[0].ena && rx_i[0].err)
      |=> err_o && !busy_o && !done_o;
  endproperty
  a_mismatch: assert property (p_mismatch) // [R18]
    else $error("corrupt segment not flagged");
  property p_mon_wait;
    @(posedge clk_i) disable iff (sys_rst_i)
    (m_reg.st == LTGM_WAIT && !link_up_i) |=> m_reg.st == LTGM_WAIT;
  endproperty
  a_mon_wait: assert property (p_mon_wait) // [R4]
    else $error("monitor left wait without link");
endmodule

// File: ltgm_core_model.sv
`timescale 1ns/1ps
`include "ltgm_regs.svh"
module ltgm_core_model (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          slow_i,
  input  ltgm_pkg::ltgm_lbus_t tx_i,
  input  wire logic          err_inj_i,
  output ltgm_pkg::ltgm_lbus_t rx_o,
  output logic               tx_rdy_o,
  output logic               locked_o,
  output logic               aligned_o,
  output logic               core_err_o
);
  import ltgm_pkg::*;
  logic [4:0] up_cnt;
  logic       inj_pend;
  // Lock comes before alignment, as a real link would report them
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      up_cnt <= 5'h00;
      inj_pend <= 1'b0;
      locked_o <= 1'b0;
      aligned_o <= 1'b0;
      tx_rdy_o <= 1'b0;
      core_err_o <= 1'b0;
      rx_o <= '0;
    end else begin
      if (up_cnt != 5'h1F) up_cnt <= up_cnt + 5'h01;
      locked_o <= (up_cnt > 5'h08);
      aligned_o <= (up_cnt > 5'h10);
      tx_rdy_o <= slow_i ? ~tx_rdy_o : 1'b1;
      core_err_o <= err_inj_i;
      // An injected error waits for the next live segment to corrupt
      inj_pend <= (inj_pend || err_inj_i) && !tx_i[0].ena;
      for (int i = 0; i < `LTGM_NSEG; i++) begin
        rx_o[i] <= tx_i[i];
        // Idle segments carry garbage so stale data never looks valid
        if (!tx_i[i].ena) rx_o[i].data <= ~rx_o[i].data;
      end
      rx_o[0].err <= tx_i[0].err ||
                     (tx_i[0].ena && (inj_pend || err_inj_i));
    end
  end
endmodule

// File: lane_traffic_gen_monitor_tb_top.sv
`timescale 1ns/1ps
`include "ltgm_regs.svh"
module lane_traffic_gen_monitor_tb_top;
  import ltgm_pkg::*;
  logic clk_i, sys_rst_i, wr_i, rd_i, restart_i, tx_ovf_i, tx_unf_i;
  logic slow, rd_d, sw_v, sw_d, burst, lock, algn, rdy, cerr, inj;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [63:0] core_txd_i, ser_rxd_i, ser_txd_o, core_rxd_o;
  logic [1:0][15:0] fc_rx_i, fc_tx_o;
  logic irq_o, tx_done_o, tx_fail_o, tx_busy_o, rx_busy_o, rx_done_o;
  logic rx_err_o, locked_o, two_clk_cfg_o;
  ltgm_lbus_t tx_o, rx_i;
  logic [63:0] rd_q[$], sw_q[$];
  int n_fail = 0, checked = 0, cyc = 0, n_sop = 0;
  always #4 clk_i = ~clk_i;
  ltgm_top #(.PKT_NUM(6)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .restart_i(restart_i),
    .serial_transceiver_locked_i(lock), .rx_aligned_i(algn), .tx_o(tx_o),
    .tx_rdy_i(rdy), .tx_ovf_i(tx_ovf_i), .tx_unf_i(tx_unf_i), .rx_i(rx_i),
    .err_inj_o(inj), .core_err_i(cerr), .fc_tx_o(fc_tx_o),
    .fc_rx_i(fc_rx_i), .core_txd_i(core_txd_i), .ser_txd_o(ser_txd_o),
    .ser_rxd_i(ser_rxd_i), .core_rxd_o(core_rxd_o), .tx_done_o(tx_done_o),
    .tx_fail_o(tx_fail_o), .tx_busy_o(tx_busy_o), .rx_busy_o(rx_busy_o),
    .rx_done_o(rx_done_o), .rx_err_o(rx_err_o), .locked_o(locked_o),
    .two_clk_cfg_o(two_clk_cfg_o));
  ltgm_core_model core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .slow_i(slow), .tx_i(tx_o), .err_inj_i(inj), .rx_o(rx_i),
    .tx_rdy_o(rdy), .locked_o(lock), .aligned_o(algn), .core_err_o(cerr));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, s);
    checked++;
    if (e !== s) begin
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rd_q.push_back({32'h0, e});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wait_done;
    int k;
    // Lets a just-requested restart clear the done levels of the last run
    repeat (2) @(posedge clk_i);
    for (k = 0; k < 400 && !(tx_done_o === 1'b1 && rx_done_o === 1'b1); k++)
      @(posedge clk_i);
    if (k == 400) chk("done", 1, 0);
  endtask
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    sw_d <= sw_v;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end else if (!sys_rst_i)
      for (int i = 0; i < `LTGM_NSEG; i++)
        if (tx_o[i].ena === 1'b1 && tx_o[i].sop === 1'b1) begin
          chk("chan", burst ? (n_sop % 2 ? `LTGM_CH_B : `LTGM_CH_A)
                            : n_sop % 256, tx_o[i].chan);
          n_sop++;
        end
  end
  // Result watcher takes the oldest note whenever a result stands
  always @(negedge clk_i) begin
    if (rd_d) chk("rdata", rd_q.pop_front(), {32'h0, rdata_o});
    if (sw_d) begin
      chk("ser_txd", sw_q.pop_front(), ser_txd_o);
      chk("core_rxd", sw_q.pop_front(), core_rxd_o);
    end
  end
  initial begin
    logic [63:0] d, e;
    clk_i = 0; sys_rst_i = 1; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0;
    restart_i = 0; tx_ovf_i = 0; tx_unf_i = 0; slow = 0; sw_v = 0;
    burst = 0; core_txd_i = 0; ser_rxd_i = 0;
    fc_rx_i = {16'h00F0, 16'h000F};
    void'($urandom(17066));
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`LTGM_A_MASK, 32'h0);
    rd(`LTGM_A_INT, 32'h0);
    rd(8'h20, 32'h0);
    wait_done();
    chk("fc_tx", 1, $onehot(fc_tx_o[0]) && fc_tx_o[1] == fc_tx_o[0]);
    rd(`LTGM_A_CNT, 32'h00060006);
    rd(`LTGM_A_STAT, 32'h000000D2);
    rd(`LTGM_A_INT, 32'h5);
    wr(`LTGM_A_MASK, 32'h4);
    @(negedge clk_i) chk("irq_on", 1, irq_o);
    wr(`LTGM_A_INT, 32'h5);
    @(negedge clk_i) chk("irq_off", 0, irq_o);
    rd(`LTGM_A_INT, 32'h0);
    rd(`LTGM_A_FC, 32'h00F0000F);
    for (int i = 0; i < 4; i++) begin
      d = {$urandom, $urandom};
      e = {$urandom, $urandom};
      @(posedge clk_i);
      core_txd_i <= d;
      ser_rxd_i <= e;
      sw_v <= 1'b1;
      sw_q.push_back({<<{d}});
      sw_q.push_back({<<{e}});
    end
    @(posedge clk_i) sw_v <= 1'b0;
    burst = 1;
    n_sop = 0;
    slow <= 1'b1;
    wr(`LTGM_A_CTRL, 32'h3);
    // Restart pin while both sides are busy must be ignored
    repeat (3) @(posedge clk_i);
    restart_i <= 1'b1;
    @(posedge clk_i) restart_i <= 1'b0;
    wait_done();
    rd(`LTGM_A_CNT, 32'h00060006);
    rd(`LTGM_A_STAT, 32'h000000D2);
    burst = 0;
    n_sop = 0;
    wr(`LTGM_A_CTRL, 32'h1);
    // Injection during the run corrupts the first received segment
    wr(`LTGM_A_CTRL, 32'h4);
    repeat (8) @(posedge clk_i);
    chk("rx_err", 1, rx_err_o);
    rd(`LTGM_A_INT, 32'h1D);
    tx_ovf_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("tx_fail", 1, tx_fail_o);
    chk("tx_busy", 0, tx_busy_o);
    chk("locked", 1, locked_o);
    chk("two_clk", 0, two_clk_cfg_o);
    end_sim();
  end
endmodule
